/* dv/ivsc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ivsc_host_model (
  input  wire logic        clk,
  output logic      [9:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic             int_ack_n,
  input  wire logic        xfer_ack_n,
  input  wire logic [7:0]  vector_out,
  input  wire logic        vector_oe
);
  initial begin
    address = 10'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    int_ack_n = 1'b1;
  end

  // Released address and data lines show the inverse so stale values are never trusted
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    address <= a;
    writedata <= {24'h00_0000, d};
    read <= !w;
    write <= w;
    // No cycle limit here; a missing answer is left to the watchdog
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~{24'h00_0000, d};
  endtask

  // Holds acknowledge request until the device answers, then releases it two clocks later
  task automatic iack(output int k, output logic [7:0] v, output logic o);
    @(posedge clk);
    int_ack_n <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (xfer_ack_n !== 1'b0);
    v = vector_out;
    o = vector_oe;
    repeat (2) @(posedge clk);
    int_ack_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule // ivsc_host_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ivsc_regs.svh"
module tb_top;
  localparam logic [9:0] A_VB = {`IVSC_IDX_VBASE, 2'b00};
  localparam logic [9:0] A_IS = {`IVSC_IDX_INT_STAT, 2'b00};
  localparam logic [9:0] A_IM = {`IVSC_IDX_INT_MASK, 2'b00};
  localparam logic [9:0] A_GC = {`IVSC_IDX_GCFG, 2'b00};
  localparam logic [9:0] A_SF = {`IVSC_IDX_SFS, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tx = 1'b0, rx = 1'b0, rxe = 1'b0, chan = 1'b1;
  logic [3:0]  oth = 4'h0;
  logic        lb_stb = 1'b0, lb_par = 1'b0, lb_frm = 1'b0;
  logic [7:0]  lb_rx = 8'h5A;
  wire  [9:0]  addr;
  wire         rd_en, wr_en, wreq, int_ack_n, xack_n, vec_oe, irq;
  wire  [31:0] wdata, rdata;
  wire  [7:0]  vec;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;

  ivsc_top #(.AV_ADDR_W(10)) i_dut (.SYS_CLK(clk), .RESET(rst), .CE(1'b1),
    .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
    .AVS_BYTEENABLE(4'h1), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .INT_ACK_N(int_ack_n), .XFER_ACK_N(xack_n),
    .VECTOR_OUT(vec), .VECTOR_OE(vec_oe), .CHAN_CODE(chan), .TX_EVT(tx),
    .RX_EVT(rx), .RX_ERR_EVT(rxe), .OTHER_EVT(oth), .LB_CMP_STB(lb_stb),
    .LB_TX_DATA(8'h5A), .LB_RX_DATA(lb_rx), .LB_PARITY_ERR(lb_par),
    .LB_FRAMING_ERR(lb_frm), .IRQ(irq));

  ivsc_host_model i_host (.clk(clk), .address(addr), .read(rd_en),
    .write(wr_en), .writedata(wdata), .readdata(rdata), .waitrequest(wreq),
    .int_ack_n(int_ack_n), .xfer_ack_n(xack_n), .vector_out(vec),
    .vector_oe(vec_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.acc(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_host.acc(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic ev(input logic [7:0] m);
    @(posedge clk);
    {oth, rxe, rx, tx} <= {m[7:4], m[2:0]};
    @(posedge clk);
    {oth, rxe, rx, tx} <= 7'h00;
  endtask

  task automatic lb(input logic [7:0] d, input logic p, input logic f);
    @(posedge clk);
    {lb_stb, lb_rx, lb_par, lb_frm} <= {1'b1, d, p, f};
    @(posedge clk);
    lb_stb <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200_000;
    n_fail++;
    report_and_stop();
  end

  initial begin : main
    logic [7:0] srcs[5];
    logic [1:0] typs[5];
    logic [7:0] v;
    logic [7:0] e;
    logic       o;
    int         k;
    srcs = '{8'h04, 8'h02, 8'h01, 8'h10, 8'h06};
    typs = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(A_GC, 8'h00);
    rchk(A_SF, 8'h00);
    rchk(A_IM, 8'h00);
    rchk(10'h3FC, 8'h00);
    $display("test reset done");
    wr(A_IM, 8'h01);
    ev(8'h11);
    rchk(A_IS, 8'h11);
    wr(A_GC, 8'h39);
    rchk(A_IS, 8'h01);
    rchk(A_GC, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(A_IS, 8'hFF);
    rchk(A_IS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test status masking done");
    wr(A_VB, 8'hA4);
    wr(A_IM, 8'hFF);
    for (int c = 0; c < 3; c++) begin
      wr(A_GC, 8'h80 | 8'(c << 1));
      ev(8'h01);
      i_host.iack(k, v, o);
      e = (c == 0) ? 8'hFF : (c == 1) ? 8'hA4 : 8'hA5;
      chk(v, e);
      chk({7'h00, o}, 8'h01);
      wr(A_IS, 8'hFF);
    end
    for (int i = 0; i < 5; i++) begin
      chan <= i[0];
      wr(A_GC, {i[1:0], 6'h06});
      ev(srcs[i]);
      i_host.iack(k, v, o);
      chk(v, {5'b1_0100, typs[i], i[0]});
      chk(8'(k), (i % 4 == 1 || i % 4 == 2) ? 8'h03 : 8'h04);
      chk({7'h00, o}, 8'h01);
      wr(A_IS, 8'hFF);
    end
    $display("test vector and delay done");
    wr(A_GC, 8'h00);
    wr(A_SF, 8'hF2);
    rchk(A_SF, 8'h02);
    lb(8'h5A, 1'b0, 1'b0);
    rchk(A_SF, 8'h02);
    for (int j = 0; j < 3; j++) begin
      lb((j == 0) ? 8'hA5 : 8'h5A, j == 1, j == 2);
      rchk(A_SF, 8'h0A);
      rchk(A_IS, 8'h08);
      chk({7'h00, irq}, 8'h01);
      wr(A_SF, 8'h02);
      rchk(A_SF, 8'h0A);
      wr(A_SF, 8'h0A);
      rchk(A_SF, 8'h02);
    end
    wr(A_SF, 8'h00);
    lb(8'hA5, 1'b1, 1'b1);
    rchk(A_SF, 8'h00);
    $display("test loopback error done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

/* rtl/ivsc_ack_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ivsc_ack_if;
  logic       start;
  logic [1:0] code;
  logic       done;
  modport ctrl  (output start, output code, input done);
  modport timer (input start, input code, output done);
endinterface : ivsc_ack_if
`default_nettype wire

/* rtl/ivsc_ack_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ivsc_regs.svh"
module ivsc_ack_timer
  import ivsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  ivsc_ack_if.timer ack
);

  localparam logic [1:0] CYC_2TO3 = 2'(`IVSC_HALF2CYC(`IVSC_DLY_2TO3_HALF));
  localparam logic [1:0] CYC_1TO2 = 2'(`IVSC_HALF2CYC(`IVSC_DLY_1TO2_HALF));
  localparam logic [1:0] CYC_HTO1 = 2'(`IVSC_HALF2CYC(`IVSC_DLY_HTO1_HALF));

  ivsc_tmr_st_t q;
  ivsc_tmr_st_t d;

  function automatic logic [1:0] dly_cycles(input logic [1:0] code);
    unique case (code)
      `IVSC_DLY_1TO2: dly_cycles = CYC_1TO2;
      `IVSC_DLY_HTO1: dly_cycles = CYC_HTO1;
      default:        dly_cycles = CYC_2TO3; // Reserved code takes longest
    endcase
  endfunction

  assign ack.done = q.run && (q.cnt == 2'h0);

  always_comb begin
    d = q;
    if (ack.start) begin
      d.run = 1'b1;
      d.cnt = dly_cycles(ack.code) - 2'h1;
    end else if (q.run) begin
      if (q.cnt == 2'h0) begin
        d.run = 1'b0;
      end else begin
        d.cnt = q.cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule // ivsc_ack_timer
`default_nettype wire

/* rtl/ivsc_pkg.sv */
package ivsc_pkg;

  typedef enum logic [1:0] {IVSC_IDLE, IVSC_WAIT, IVSC_ACK} ivsc_ack_st_t;

  typedef struct packed {
    logic [7:0]   vbase;
    logic [7:0]   gcfg;
    logic [7:0]   int_mask;
    logic [7:0]   int_stat;
    logic [1:0]   lb_mode;
    logic         waitreq;
    logic [7:0]   rdata;
    logic         irq;
    logic         xack_n;
    logic [7:0]   vec;
    logic         vec_oe;
    ivsc_ack_st_t ack_st;
  } ivsc_main_st_t;

  typedef struct packed {
    logic       run;
    logic [1:0] cnt;
  } ivsc_tmr_st_t;

endpackage : ivsc_pkg

/* rtl/ivsc_regs.svh */
`ifndef IVSC_REGS_SVH
`define IVSC_REGS_SVH

// Register indices; byte address is four times the index
`define IVSC_IDX_VBASE     8'h60
`define IVSC_IDX_INT_STAT  8'h61
`define IVSC_IDX_INT_MASK  8'h62
`define IVSC_IDX_GCFG      8'h66
`define IVSC_IDX_SFS       8'h45

// global_configuration fields
`define IVSC_GC_STMASK     0
`define IVSC_GC_VCTL_LO    1
`define IVSC_GC_VCTL_HI    2
`define IVSC_GC_DLY_LO     6
`define IVSC_GC_DLY_HI     7
`define IVSC_GC_WMASK      8'hC7

// special_feature_status fields
`define IVSC_SF_LBMODE_LO  1
`define IVSC_SF_LBMODE_HI  2
`define IVSC_SF_LBERR      3

// Interrupt status bits
`define IVSC_IS_TX         0
`define IVSC_IS_RX         1
`define IVSC_IS_RXERR      2
`define IVSC_IS_LB         3
`define IVSC_IS_OTH_LO     4
`define IVSC_IS_OTH_HI     7

// Vector control codes
`define IVSC_VCTL_NONE     2'h0
`define IVSC_VCTL_BASE     2'h1
`define IVSC_VCTL_CHAN     2'h2
`define IVSC_VCTL_TYPE     2'h3
`define IVSC_VEC_NONE      8'hFF

// Interrupt type codes
`define IVSC_TYPE_RXOK     2'h2
`define IVSC_TYPE_RXERR    2'h3
`define IVSC_TYPE_TX       2'h1
`define IVSC_TYPE_OTHER    2'h0

// Acknowledge delay codes and least delays in half system clocks
`define IVSC_DLY_2TO3      2'h0
`define IVSC_DLY_1TO2      2'h1
`define IVSC_DLY_HTO1      2'h2
`define IVSC_DLY_2TO3_HALF 4
`define IVSC_DLY_1TO2_HALF 2
`define IVSC_DLY_HTO1_HALF 1
`define IVSC_HALF2CYC(h)   (((h) + 1) / 2)

`define IVSC_RST_BYTE      8'h00
`define IVSC_LBMODE_OFF    2'h0

`endif

/* rtl/ivsc_top.sv */
// Function
// - Type code: rx ok 10, rx error 11, transmitter 01, others 00.
// - Vector control 11 keeps base bits 7:3; type and channel fill 2:0.
// - Vector control 00 gives no vector; bus driven to all ones.
// - Masking bit set: status reads are ANDed with the interrupt mask.
// - Masking bit clear: status reads show raw latched status.
// - Acknowledge delay codes 00, 01, 10 give 2-3, 1-2, half-1 clocks; here code 10 gives 1-2 clocks, the same as 01.
// - Loopback error sets sticky status bit 3, joining interrupt arbitration.
// - Writing one to bit 3 of the status register clears the flag.
// - Mismatch, parity or framing error on loopback check raises error.
`timescale 1ns/100ps
`default_nettype none
`include "ivsc_regs.svh"
module ivsc_top
  import ivsc_pkg::*;
#(
  parameter int AV_ADDR_W = 10
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic [AV_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        INT_ACK_N,
  output logic             XFER_ACK_N,
  output logic      [7:0]  VECTOR_OUT,
  output logic             VECTOR_OE,
  input  wire logic        CHAN_CODE,
  input  wire logic        TX_EVT,
  input  wire logic        RX_EVT,
  input  wire logic        RX_ERR_EVT,
  input  wire logic [3:0]  OTHER_EVT,
  input  wire logic        LB_CMP_STB,
  input  wire logic [7:0]  LB_TX_DATA,
  input  wire logic [7:0]  LB_RX_DATA,
  input  wire logic        LB_PARITY_ERR,
  input  wire logic        LB_FRAMING_ERR,
  output logic             IRQ
);

  // Address bits 9:2 pick the register, so a narrower bus cannot decode
  if (AV_ADDR_W < 10 || AV_ADDR_W > 32) begin : g_bad_addr_w
    $error("AV_ADDR_W must lie between 10 and 32");
  end

  ivsc_main_st_t q;
  ivsc_main_st_t d;
  ivsc_ack_if    ack ();

  logic [7:0]           idx;
  logic                 hi_zero;
  logic                 req;
  logic                 wr;
  logic [7:0]           wdat;
  logic                 lb_evt;
  logic [7:0]           set;
  logic [7:0]           clr;
  logic [7:0]           pend;
  logic [1:0]           vctl;

  function automatic logic [1:0] int_type(input logic [7:0] p);
    if (p[`IVSC_IS_RXERR]) begin
      int_type = `IVSC_TYPE_RXERR;
    end else if (p[`IVSC_IS_RX]) begin
      int_type = `IVSC_TYPE_RXOK;
    end else if (p[`IVSC_IS_TX]) begin
      int_type = `IVSC_TYPE_TX;
    end else begin
      int_type = `IVSC_TYPE_OTHER;
    end
  endfunction

  function automatic logic [7:0] make_vec(input logic [1:0] ctl,
                                          input logic [7:0] base,
                                          input logic [1:0] typ,
                                          input logic       chan);
    unique case (ctl)
      `IVSC_VCTL_NONE: make_vec = `IVSC_VEC_NONE;
      `IVSC_VCTL_BASE: make_vec = base;
      `IVSC_VCTL_CHAN: make_vec = {base[7:1], chan};
      `IVSC_VCTL_TYPE: make_vec = {base[7:3], typ, chan};
    endcase
  endfunction

  ivsc_ack_timer u_timer (
    .clk (SYS_CLK),
    .rst (RESET),
    .ce  (CE),
    .ack (ack.timer)
  );

  assign idx     = AVS_ADDRESS[9:2];
  assign hi_zero = (AV_ADDR_W == 10) ? 1'b1 :
                   ((AVS_ADDRESS >> 10) == '0);
  assign req     = AVS_READ || AVS_WRITE;
  assign wr      = AVS_WRITE && !q.waitreq && AVS_BYTEENABLE[0] && hi_zero;
  assign wdat    = AVS_WRITEDATA[7:0];
  assign vctl    = q.gcfg[`IVSC_GC_VCTL_HI:`IVSC_GC_VCTL_LO];
  assign pend    = q.int_stat & q.int_mask;

  // Loopback check only counts while a check mode is selected
  assign lb_evt  = LB_CMP_STB && (q.lb_mode != `IVSC_LBMODE_OFF) &&
                   ((LB_TX_DATA != LB_RX_DATA) || LB_PARITY_ERR ||
                    LB_FRAMING_ERR);

  assign ack.code  = q.gcfg[`IVSC_GC_DLY_HI:`IVSC_GC_DLY_LO];
  assign ack.start = (q.ack_st == IVSC_IDLE) && !INT_ACK_N;

  always_comb begin
    d   = q;
    set = {OTHER_EVT, lb_evt, RX_ERR_EVT, RX_EVT, TX_EVT};
    clr = 8'h00;
    // Bus slave: one wait cycle, then completion
    d.waitreq = !(req && q.waitreq);
    if (req && q.waitreq) begin
      d.rdata = `IVSC_RST_BYTE;
      if (AVS_READ && hi_zero) begin
        unique case (idx)
          `IVSC_IDX_VBASE:    d.rdata = q.vbase;
          `IVSC_IDX_INT_STAT: d.rdata = q.gcfg[`IVSC_GC_STMASK] ?
                                        pend :
                                        q.int_stat;
          `IVSC_IDX_INT_MASK: d.rdata = q.int_mask;
          `IVSC_IDX_GCFG:     d.rdata = q.gcfg;
          `IVSC_IDX_SFS: begin
            d.rdata[`IVSC_SF_LBERR] = q.int_stat[`IVSC_IS_LB];
            d.rdata[`IVSC_SF_LBMODE_HI:`IVSC_SF_LBMODE_LO] = q.lb_mode;
          end
          default:            d.rdata = `IVSC_RST_BYTE;
        endcase
      end
    end
    if (wr) begin
      unique case (idx)
        `IVSC_IDX_VBASE:    d.vbase = wdat;
        `IVSC_IDX_INT_STAT: clr = wdat;
        `IVSC_IDX_INT_MASK: d.int_mask = wdat;
        `IVSC_IDX_GCFG:     d.gcfg = wdat & `IVSC_GC_WMASK;
        `IVSC_IDX_SFS: begin
          // Only bit 3 clears; reserved bits dropped
          clr[`IVSC_IS_LB] = wdat[`IVSC_SF_LBERR];
          d.lb_mode = wdat[`IVSC_SF_LBMODE_HI:`IVSC_SF_LBMODE_LO];
        end
        default: ;
      endcase
    end
    // Set beats a simultaneous clear
    d.int_stat = (q.int_stat & ~clr) | set;
    d.irq      = |(d.int_stat & d.int_mask);
    // Interrupt acknowledge cycle
    unique case (q.ack_st)
      IVSC_IDLE: begin
        if (!INT_ACK_N) begin
          d.vec    = make_vec(vctl, q.vbase, int_type(pend),
                              CHAN_CODE);
          d.ack_st = IVSC_WAIT;
        end
      end
      IVSC_WAIT: begin
        if (INT_ACK_N) begin
          d.ack_st = IVSC_IDLE;
        end else if (ack.done) begin
          d.xack_n = 1'b0;
          d.vec_oe = 1'b1;
          d.ack_st = IVSC_ACK;
        end
      end
      IVSC_ACK: begin
        if (INT_ACK_N) begin
          d.xack_n = 1'b1;
          d.vec_oe = 1'b0;
          d.ack_st = IVSC_IDLE;
        end
      end
      // Unused fourth code falls back to idle with the bus released
      default: begin
        d.xack_n = 1'b1;
        d.vec_oe = 1'b0;
        d.ack_st = IVSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      q         <= '0;
      q.waitreq <= 1'b1;
      q.xack_n  <= 1'b1;
      q.ack_st  <= IVSC_IDLE;
    end else if (CE) begin
      q <= d;
    end
  end

  assign AVS_READDATA    = {24'h00_0000, q.rdata};
  assign AVS_WAITREQUEST = q.waitreq;
  assign XFER_ACK_N      = q.xack_n;
  assign VECTOR_OUT      = q.vec;
  assign VECTOR_OE       = q.vec_oe;
  assign IRQ             = q.irq;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  logic rd_stat;
  logic wr_sfs;
  assign rd_stat = AVS_READ && q.waitreq && CE && hi_zero &&
                   (idx == `IVSC_IDX_INT_STAT);
  assign wr_sfs  = wr && CE && (idx == `IVSC_IDX_SFS);

  vec_type_code_a: assert property (
    (ack.start && CE && vctl == `IVSC_VCTL_TYPE)
      |=> (VECTOR_OUT[2:1] == $past(int_type(pend))))
    else $error("vector type code wrong");

  vec_base_keep_a: assert property (
    (ack.start && CE && vctl == `IVSC_VCTL_TYPE)
      |=> (VECTOR_OUT[7:3] == q.vbase[7:3]) &&
          (VECTOR_OUT[0] == $past(CHAN_CODE)))
    else $error("vector base or channel bits wrong");

  vec_none_ones_a: assert property (
    (ack.start && CE && vctl == `IVSC_VCTL_NONE)
      |=> (VECTOR_OUT == `IVSC_VEC_NONE))
    else $error("absent vector not all ones");

  stat_masked_a: assert property (
    (rd_stat && q.gcfg[`IVSC_GC_STMASK])
      |=> (AVS_READDATA[7:0] == $past(pend)) && !AVS_WAITREQUEST)
    else $error("masked status read wrong");

  stat_raw_a: assert property (
    (rd_stat && !q.gcfg[`IVSC_GC_STMASK])
      |=> (AVS_READDATA[7:0] == $past(q.int_stat)))
    else $error("raw status read wrong");

  ack_dly_long_a: assert property (
    (ack.start && CE && ack.code == `IVSC_DLY_2TO3)
      ##1 (CE && !INT_ACK_N) [*2]
      |-> XFER_ACK_N ##1 !XFER_ACK_N)
    else $error("long acknowledge delay wrong");

  ack_dly_short_a: assert property (
    (ack.start && CE && ack.code == `IVSC_DLY_1TO2)
      ##1 (CE && !INT_ACK_N)
      |=> !XFER_ACK_N && VECTOR_OE)
    else $error("short acknowledge delay wrong");

  lb_err_set_a: assert property (
    (lb_evt && CE) |=> q.int_stat[`IVSC_IS_LB])
    else $error("loopback error not flagged");

  lb_err_clr_a: assert property (
    (wr_sfs && wdat[`IVSC_SF_LBERR] && !lb_evt)
      |=> !q.int_stat[`IVSC_IS_LB])
    else $error("loopback error not cleared");

  lb_err_irq_a: assert property (
    (lb_evt && CE && q.int_mask[`IVSC_IS_LB] && !wr) |=> IRQ)
    else $error("loopback error gave no interrupt");

  lb_err_hold_a: assert property (
    (wr_sfs && !wdat[`IVSC_SF_LBERR] && q.int_stat[`IVSC_IS_LB])
      |=> q.int_stat[`IVSC_IS_LB])
    else $error("loopback error lost on zero write");

  ack_dly_mid_a: assert property (
    (ack.start && CE && ack.code == `IVSC_DLY_HTO1)
      ##1 (CE && !INT_ACK_N)
      |=> !XFER_ACK_N)
    else $error("half clock acknowledge delay wrong");

  ack_release_a: assert property (
    (!XFER_ACK_N && INT_ACK_N && CE) |=> XFER_ACK_N && !VECTOR_OE)
    else $error("acknowledge not released");

  ack_oe_pair_a: assert property (
    VECTOR_OE == !XFER_ACK_N)
    else $error("vector enable and acknowledge disagree");

  vec_hold_a: assert property (
    (!XFER_ACK_N && CE) |=> $stable(VECTOR_OUT))
    else $error("vector changed during acknowledge");

  lb_off_quiet_a: assert property (
    (LB_CMP_STB && CE && q.lb_mode == `IVSC_LBMODE_OFF &&
     !q.int_stat[`IVSC_IS_LB]) |=> !q.int_stat[`IVSC_IS_LB])
    else $error("loopback error raised with check off");

  cov_ack_long_c: cover property (
    (ack.start && CE && ack.code == `IVSC_DLY_2TO3) ##[1:8] !XFER_ACK_N);
  cov_vec_type_c: cover property (
    ack.start && CE && vctl == `IVSC_VCTL_TYPE ##[1:8] !XFER_ACK_N);
  cov_lb_clear_c: cover property (
    (lb_evt && CE) ##[1:20] (wr_sfs && wdat[`IVSC_SF_LBERR]));
  cov_mask_rd_c: cover property (
    rd_stat && q.gcfg[`IVSC_GC_STMASK] && (q.int_stat != pend));

endmodule // ivsc_top
`default_nettype wire
